// file: event_host_model.sv
// Purpose: Host model for the event line
// Assumes: Bench resolves the line with pull-down
// Notes: Drives only at falling edges
`timescale 1ns/1ns
`default_nettype none
module event_host_model #(parameter int PW = 3, QUIET = 5, HOLD = 6) (
  input wire logic clk,
  input wire logic go,
  input wire logic line,
  output logic drv,
  output logic drv_oe,
  output int n_seen
);
  logic mask = 1'b0; // Interrupt mask
  logic last = 1'b0; // Line at last edge
  logic trig_oe = 1'b0; // Enable while sending a trigger
  logic clr_oe = 1'b0; // Enable while clearing after completion
  initial {drv, n_seen} = '0;
  // One enable on the pin, whichever duty holds it
  assign drv_oe = trig_oe || clr_oe;
  // Trigger: mask, high, low, release, settle
  always @(posedge go) begin
    mask = 1'b1;
    @(negedge clk) {trig_oe, drv} = 2'h3;
    repeat (PW) @(negedge clk);
    drv = 1'b0;
    @(negedge clk) trig_oe = 1'b0;
    repeat (QUIET) @(negedge clk);
    mask = 1'b0;
  end
  // Completion: clear line low, then release
  always @(negedge clk) begin
    if (!mask && line && !last) begin
      n_seen++;
      clr_oe = 1'b1;
      repeat (HOLD) @(negedge clk);
      clr_oe = 1'b0;
    end
    last = line;
  end
endmodule : event_host_model
`default_nettype wire

// file: event_line_pkg.sv
// Purpose: Types for the ultrasonic event line device logic
// Assumes: Included constants header supplies widths
// Notes: No imports; users write event_line_pkg::name
`include "event_line_regs.svh"

package event_line_pkg;

  // Measurement sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_BURST,
    ST_LISTEN,
    ST_REPORT
  } meas_state_e;

  // Event line pin driver pair
  typedef struct packed {
    logic out;
    logic oe;
  } line_drive_s;

  // Result carried to the host
  typedef struct packed {
    logic valid;
    logic echo_found;
    logic [`TOF_W-1:0] time_of_flight;
  } tof_result_s;

endpackage : event_line_pkg

// file: event_line_regs.svh
// Purpose: Constants for the ultrasonic event line device logic
// Assumes: 250 MHz clock, 4 ns period
// Notes: Completion pulse time is given in ns and converted to cycles here
`ifndef EVENT_LINE_REGS_SVH
`define EVENT_LINE_REGS_SVH

// Clock period in ns
`define CLK_PERIOD_NS 4
// Completion pulse width in ns (within the 1-10 us window)
`define DONE_PULSE_NS 2000
// Completion pulse width in cycles, rounded down as a longest time
`define DONE_PULSE_CYC (`DONE_PULSE_NS / `CLK_PERIOD_NS)
// Burst length in cycles
`define BURST_CYC 100
// Listening window in cycles (maximum range)
`define LISTEN_CYC 4000
// Width of the time of flight result
`define TOF_W 16
// Echo detection threshold on the sample magnitude
`define ECHO_THRESH 8'h40

`endif

// file: ultrasonic_event_line.sv
// Purpose: Device side of the single wire event line with measurement sequencer
// Assumes: All inputs except rst_n synchronous to clk; external pull-down returns line low
// Notes: Line is driven high only; release relies on pull-down
`timescale 1ns/1ns
`default_nettype none
`include "event_line_regs.svh"

module ultrasonic_event_line #(
  parameter int TOF_W = `TOF_W,
  parameter int BURST_CYC = `BURST_CYC,
  parameter int LISTEN_CYC = `LISTEN_CYC,
  parameter int DONE_CYC = `DONE_PULSE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  // Event line, sensor side, input level
  input wire logic event_line_sensor_side_in,
  // Event line drive level
  output logic event_line_sensor_side_out,
  // Event line output enable, high while driving
  output logic event_line_sensor_side_oe,
  // Hardware trigger operation selected
  input wire logic hw_trigger_mode,
  // Host calibrating the internal clock
  input wire logic calib_active,
  // Programming select, active high
  input wire logic program_select,
  // Received sound sample magnitude
  input wire logic [7:0] rx_sample,
  // Transmit burst enable to the transducer
  output logic tx_burst,
  // Listening phase active
  output logic rx_listen,
  // Measured time of flight result
  output event_line_pkg::tof_result_s result,
  // Measurement in progress
  output logic busy
);

  // Reset synchroniser stages
  logic rst_meta_reg;
  logic rst_sync_reg;
  // Sequencer state
  event_line_pkg::meas_state_e state_reg;
  // Phase cycle counter
  logic [15:0] cnt_reg;
  // Previous event line level for edge detection
  logic line_prev_reg;
  // Completion pulse width counter
  logic [15:0] done_cnt_reg;
  // Echo seen during the current listen
  logic echo_seen_reg;
  // Captured flight time
  logic [TOF_W-1:0] tof_reg;
  // Flight time counter since burst start
  logic [TOF_W-1:0] tof_cnt_reg;

  // Rising edge seen on line while not driving it
  logic trig_edge;
  // Device allowed to start a measurement on a line trigger
  logic run_ok;

  // Release of asynchronous reset through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // Programming select high blocks new triggers; a measurement in progress runs on
  assign run_ok = !program_select;
  // Line taken as input only while not driving it
  assign trig_edge = event_line_sensor_side_in && !line_prev_reg
                     && !event_line_sensor_side_oe;

  // Line level history
  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      line_prev_reg <= 1'b0;
    end else begin
      line_prev_reg <= event_line_sensor_side_in;
    end
  end

  // Measurement sequencer
  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg <= event_line_pkg::ST_IDLE;
      cnt_reg <= 16'h0000;
    end else begin
      case (state_reg)
        event_line_pkg::ST_IDLE: begin
          // Trigger edge ignored during calibration
          if (run_ok && hw_trigger_mode && !calib_active && trig_edge) begin
            state_reg <= event_line_pkg::ST_BURST;
            cnt_reg <= 16'h0000;
          end
        end
        event_line_pkg::ST_BURST: begin
          // Short burst then straight into listening
          if (cnt_reg == 16'(BURST_CYC - 1)) begin
            state_reg <= event_line_pkg::ST_LISTEN;
            cnt_reg <= 16'h0000;
          end else begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
        event_line_pkg::ST_LISTEN: begin
          // Listen for the full range window
          if (cnt_reg == 16'(LISTEN_CYC - 1)) begin
            state_reg <= event_line_pkg::ST_REPORT;
            cnt_reg <= 16'h0000;
          end else begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
        event_line_pkg::ST_REPORT: begin
          // Hold until completion pulse ends
          if (done_cnt_reg == 16'(DONE_CYC - 1)) begin
            state_reg <= event_line_pkg::ST_IDLE;
          end
        end
        default: begin
          state_reg <= event_line_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Flight time counter and echo capture
  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      tof_cnt_reg <= '0;
      echo_seen_reg <= 1'b0;
      tof_reg <= '0;
    end else if (state_reg == event_line_pkg::ST_IDLE) begin
      tof_cnt_reg <= '0;
      echo_seen_reg <= 1'b0;
    end else if (state_reg != event_line_pkg::ST_REPORT) begin
      tof_cnt_reg <= tof_cnt_reg + 1'b1;
      // First sample at or above threshold is the echo
      if (state_reg == event_line_pkg::ST_LISTEN && !echo_seen_reg
          && rx_sample >= `ECHO_THRESH) begin
        echo_seen_reg <= 1'b1;
        tof_reg <= tof_cnt_reg;
      end
    end
  end

  // Completion pulse width counter
  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      done_cnt_reg <= 16'h0000;
    end else if (state_reg == event_line_pkg::ST_REPORT) begin
      done_cnt_reg <= done_cnt_reg + 16'h0001;
    end else begin
      done_cnt_reg <= 16'h0000;
    end
  end

  // Line driver: high only during completion pulse, then released
  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      event_line_sensor_side_out <= 1'b0;
      event_line_sensor_side_oe <= 1'b0;
    end else if (state_reg == event_line_pkg::ST_LISTEN
                 && cnt_reg == 16'(LISTEN_CYC - 1)) begin
      event_line_sensor_side_out <= 1'b1;
      event_line_sensor_side_oe <= 1'b1;
    end else if (state_reg == event_line_pkg::ST_REPORT
                 && done_cnt_reg == 16'(DONE_CYC - 1)) begin
      event_line_sensor_side_out <= 1'b0;
      event_line_sensor_side_oe <= 1'b0;
    end
  end

  // Result publication on completion
  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      result <= '0;
    end else if (state_reg == event_line_pkg::ST_LISTEN
                 && cnt_reg == 16'(LISTEN_CYC - 1)) begin
      result.valid <= 1'b1;
      result.echo_found <= echo_seen_reg;
      result.time_of_flight <= tof_reg;
    end else if (state_reg == event_line_pkg::ST_BURST) begin
      result.valid <= 1'b0;
    end
  end

  // Transducer and status outputs
  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      tx_burst <= 1'b0;
      rx_listen <= 1'b0;
      busy <= 1'b0;
    end else begin
      tx_burst <= (state_reg == event_line_pkg::ST_BURST)
                  && (cnt_reg != 16'(BURST_CYC - 1));
      rx_listen <= (state_reg == event_line_pkg::ST_LISTEN)
                   && (cnt_reg != 16'(LISTEN_CYC - 1));
      busy <= (state_reg != event_line_pkg::ST_IDLE);
    end
  end

endmodule : ultrasonic_event_line
`default_nettype wire

// file: ultrasonic_event_line_chk.sv
// Purpose: Port checker for the event line device
// Assumes: Bound into each device instance
// Notes: Counts handed on by the bind
`timescale 1ns/1ns
`default_nettype none
module ultrasonic_event_line_chk #(parameter int BURST_CYC = 5, DONE_CYC = 4) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic event_line_sensor_side_in,
  input wire logic event_line_sensor_side_out,
  input wire logic event_line_sensor_side_oe,
  input wire logic hw_trigger_mode,
  input wire logic calib_active,
  input wire logic program_select,
  input wire logic tx_burst,
  input wire logic rx_listen,
  input wire event_line_pkg::tof_result_s result,
  input wire logic busy
);
  localparam int BL = BURST_CYC - 1;
  wire logic ev = event_line_sensor_side_in; // Line level
  wire logic oe = event_line_sensor_side_oe; // Device drive
  wire logic idle = !oe && !busy; // Free to accept
  wire logic ok = hw_trigger_mode && !calib_active && !program_select; // Trigger allowed
  int oe_cnt; // Cycles the device has driven the line so far
  // Length of the current completion drive
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oe_cnt <= 0;
    end else if (oe) begin
      oe_cnt <= oe_cnt + 1;
    end else begin
      oe_cnt <= 0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_TRIG: assert property ($rose(ev) && idle && ok |-> ##2 tx_burst && busy)
    else $error("trigger lost");
  AST_REFUSE: assert property ($rose(ev) && idle && !ok |-> ##2 !tx_burst)
    else $error("trigger not refused");
  AST_BURST: assert property ($rose(tx_burst) |-> ##BL $fell(tx_burst))
    else $error("burst width");
  AST_LISTEN: assert property ($fell(tx_burst) |-> ##[0:1] rx_listen)
    else $error("no listen");
  AST_DONE: assert property ($fell(rx_listen) |-> ##[0:1] oe && result.valid)
    else $error("no completion");
  AST_PULSE: assert property (oe |-> oe_cnt < DONE_CYC)
    else $error("pulse too long");
  AST_PULSE_END: assert property ($fell(oe) |-> oe_cnt == DONE_CYC)
    else $error("pulse width");
  AST_HIGH: assert property (oe |-> event_line_sensor_side_out)
    else $error("driven low");
  AST_BUSY: assert property ($fell(oe) |=> !busy)
    else $error("busy stuck");
  cover property ($rose(tx_burst));
  cover property (result.valid && result.echo_found);
  cover property ($fell(oe));
endmodule : ultrasonic_event_line_chk
bind ultrasonic_event_line ultrasonic_event_line_chk #(.BURST_CYC(BURST_CYC),
  .DONE_CYC(DONE_CYC)) chk_u (
  .clk(clk),
  .rst_n(rst_n),
  .event_line_sensor_side_in(event_line_sensor_side_in),
  .event_line_sensor_side_out(event_line_sensor_side_out),
  .event_line_sensor_side_oe(event_line_sensor_side_oe),
  .hw_trigger_mode(hw_trigger_mode),
  .calib_active(calib_active),
  .program_select(program_select),
  .tx_burst(tx_burst),
  .rx_listen(rx_listen),
  .result(result),
  .busy(busy)
);
`default_nettype wire

// file: ultrasonic_event_line_tb.sv
// Purpose: Bench for the event line device
// Assumes: Short counts set as parameters
// Notes: Inputs change at falling edges
`timescale 1ns/1ns
`default_nettype none
module ultrasonic_event_line_tb;
  logic clk, rst_n, hw, cal, psel, go, d_out, d_oe, h_drv, h_oe, txb, rxl, busy;
  logic [7:0] smp;
  logic [15:0] t1, t2;
  event_line_pkg::tof_result_s res;
  int failures = 0, n_compared = 0, n_seen, i;
  localparam int BURST = 5; // Short burst for the bench
  // Device, else host, else pull-down
  wire logic line = d_oe ? d_out : h_oe & h_drv;
  ultrasonic_event_line #(.BURST_CYC(BURST), .LISTEN_CYC(50), .DONE_CYC(4)) dut_u (.clk, .rst_n,
    .event_line_sensor_side_in(line), .event_line_sensor_side_out(d_out),
    .event_line_sensor_side_oe(d_oe), .hw_trigger_mode(hw), .calib_active(cal),
    .program_select(psel), .rx_sample(smp), .tx_burst(txb), .rx_listen(rxl),
    .result(res), .busy);
  event_host_model host_u (.clk, .go, .line, .drv(h_drv), .drv_oe(h_oe), .n_seen);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [17:0] g, input logic [17:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("FAIL %0t %h %h", $time, g, e);
    end
  endtask : chk
  task automatic test_done;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  task automatic pulse;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
  endtask : pulse
  // Echo k cycles into listening, loud burst, optional stray trigger
  task automatic meas(input int k, input logic e, input logic stray, output logic [15:0] t);
    int n;
    n = n_seen;
    smp = 8'h7F;
    pulse;
    // Loud samples must be gone before the first listening sample
    for (i = 0; i < 99 && !txb; i++) @(negedge clk);
    chk({17'h0, txb}, 18'h1);
    for (i = 0; i < 99 && txb; i++) @(negedge clk);
    smp = 8'h3F;
    repeat (k) @(negedge clk);
    chk({17'h0, rxl}, {17'h0, k != 0});
    smp = {1'b0, e, 6'h00};
    if (stray) pulse;
    for (i = 0; i < 99 && n_seen == n; i++) @(negedge clk) chk({17'h0, txb}, 18'h0);
    chk({17'h0, n_seen != n}, 18'h1);
    chk({16'h0, res.valid, res.echo_found}, {16'h0, 1'b1, e});
    // Flight time counts from burst start to the echo sample
    if (e) chk({2'h0, res.time_of_flight}, 18'(BURST + k));
    for (i = 0; i < 20 && busy; i++) @(negedge clk);
    repeat (8) @(negedge clk);
    chk({16'h0, busy, rxl}, 18'h0);
    chk({17'h0, line}, 18'h0);
    t = res.time_of_flight;
  endtask : meas
  // Blocked trigger starts nothing
  task automatic refuse(input logic h, input logic c, input logic p);
    {hw, cal, psel} = {h, c, p};
    pulse;
    repeat (12) @(negedge clk) chk({17'h0, busy}, 18'h0);
    {hw, cal, psel} = 3'h4;
  endtask : refuse
  initial begin
    {rst_n, hw, cal, psel, go, smp} = 13'h0800;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    meas(3, 1'b1, 1'b0, t1);
    meas(12, 1'b1, 1'b1, t2);
    chk({2'h0, t2 - t1}, 18'h09);
    // Host halves the round trip to get the one-way range figure
    chk({2'h0, t2 >> 1}, 18'((BURST + 12) / 2));
    meas(5, 1'b0, 1'b0, t1);
    refuse(1'b0, 1'b0, 1'b0);
    refuse(1'b1, 1'b1, 1'b0);
    refuse(1'b1, 1'b0, 1'b1);
    meas(0, 1'b1, 1'b0, t1);
    test_done;
  end
  // Watchdog
  initial begin
    #20000;
    failures++;
    test_done;
  end
endmodule : ultrasonic_event_line_tb
`default_nettype wire
